// ==== slcd_pkg.sv ====
// Functional notes
// - Mode byte bit3 switches panel; reset off.
// - Command off blanks outputs at the next frame end.
// - Command on enables outputs and RAM scan.
// - Inhibit pin blanks outputs immediately, unsynchronised.
// - Mode byte bit2 picks half bias; reset third.
// - Address byte low five bits plus stored MSB.
// - Address above 22h forces 00h; reset 00h.
// - Counter loads on address-set command or soft reset.
// - Write at 22h wraps counter to 00h.
// - Counter persists across commands and frames.
// - Control byte bits4..3 pick frame rate.
// - External clock divided by 512/576/648/768.
// - Control byte bit2 picks frame inversion.
// - Control byte bits1..0 pick drive strength.
// - Operation byte bit2 stores address MSB.
// - Operation bit1 soft-resets, dropping bits 2,1.
// - Soft reset blanks panel, restores config defaults except clock select, clears counter; RAM kept.
// - Operation bit0 selects external logic clock.
// - Blink byte bits1..0 store blink mode.
// - Command bit7 clear marks next byte data.
// - Data state holds until chip select rises.
// - Data byte writes two nibbles, counter advancing.
// - Sample rising edge, byte at eighth fall.
// - Partial command dropped when chip select rises.
`default_nettype none
package slcd_pkg;
  // Widths
  localparam int ADDR_W = 6;
  localparam int NIB_W = 4;
  localparam int BYTE_W = 8;
  localparam int ENTRY_W = 9;
  localparam int FRAME_W = 10;
  localparam int OSC_W = 16;
  localparam int RAM_DEPTH = 35;
  localparam int FIFO_DEPTH = 4;
  // Address range of the display RAM
  localparam logic [5:0] ADDR_FIRST = 6'h00;
  localparam logic [5:0] ADDR_LAST = 6'h22;
  localparam logic [5:0] ADDR_STEP = 6'h01;
  // Command byte fields
  localparam int CD_BIT = 7;
  localparam int GRP_HI = 6;
  localparam int GRP_LO = 5;
  localparam int OP_LO = 3;
  localparam int PANEL_BIT = 3;
  localparam int BIAS_BIT = 2;
  localparam int RATE_HI = 4;
  localparam int RATE_LO = 3;
  localparam int WAVE_BIT = 2;
  localparam int MSB_BIT = 2;
  localparam int SRST_BIT = 1;
  localparam int CLKSEL_BIT = 0;
  localparam int ADDR_LO_HI = 4;
  // Opcode patterns
  localparam logic [1:0] GRP_ADDR = 2'h0;
  localparam logic [1:0] GRP_DCTL = 2'h1;
  localparam logic [1:0] GRP_MODE = 2'h2;
  localparam logic [3:0] OP_CHIP = 4'hD;
  localparam logic [3:0] OP_BLINK = 4'hE;
  // Serial bit counts
  localparam logic [3:0] BITS_NIB = 4'h4;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BITS_STEP = 4'h1;
  // Logic-clock ticks per frame for each rate
  localparam logic [9:0] DIV_80 = 10'h200;
  localparam logic [9:0] DIV_71 = 10'h240;
  localparam logic [9:0] DIV_64 = 10'h288;
  localparam logic [9:0] DIV_53 = 10'h300;
  localparam logic [9:0] FRAME_STEP = 10'h001;
  localparam logic [15:0] OSC_STEP = 16'h0001;
  // Default internal oscillator divider, in clk cycles per tick
  localparam logic [15:0] OSC_DIV_DEF = 16'h0040;
  // Configuration encodings
  typedef enum logic {BIAS_THIRD, BIAS_HALF} slcd_bias_t;
  typedef enum logic [1:0] {RATE_80, RATE_71, RATE_64, RATE_53} slcd_rate_t;
  typedef enum logic {WAVE_LINE, WAVE_FRAME} slcd_wave_t;
  typedef enum logic [1:0] {PWR_SAVE1, PWR_SAVE2, PWR_NORMAL, PWR_HIGH}
    slcd_power_t;
  typedef enum logic {CLK_INTERNAL, CLK_EXTERNAL} slcd_clksrc_t;
  // Serial link framing state
  typedef enum logic [1:0] {LINK_IDLE, LINK_CMD, LINK_DATA} slcd_link_t;
  // Reset values
  localparam logic [1:0] BLINK_RST = 2'h0;
endpackage : slcd_pkg
`default_nettype wire

// ==== slcd_fifo.sv ====
`default_nettype none
module slcd_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] CNT_FULL = (PW+1)'(DEPTH);
  // Pointer state
  typedef struct packed {
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0] cnt;
  } slcd_fifo_state_t;
  slcd_fifo_state_t s_r, s_nxt;
  logic [WIDTH-1:0] mem [DEPTH];  // Storage words
  logic push, pop;

  // Honest flags straight from the occupancy count
  assign in_ready = (s_r.cnt != CNT_FULL);
  assign out_valid = (s_r.cnt != '0);
  assign out_data = mem[s_r.rd];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointer and count update, wrapping at DEPTH
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.wr = (s_r.wr == PW'(DEPTH - 1)) ? '0 : s_r.wr + PW'(1);
    end
    if (pop) begin
      s_nxt.rd = (s_r.rd == PW'(DEPTH - 1)) ? '0 : s_r.rd + PW'(1);
    end
    s_nxt.cnt = s_r.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Storage write, no reset needed for data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[s_r.wr] <= in_data;
    end
  end
endmodule : slcd_fifo
`default_nettype wire

// ==== slcd_ram.sv ====
`default_nettype none
module slcd_ram #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 35,
  parameter int AW = 6
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);
  // Contents survive any reset on purpose
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rdata_r;

  assign rdata = rdata_r;

  // Single port, registered read
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata_r <= mem[addr];
  end
endmodule : slcd_ram
`default_nettype wire

// ==== slcd_core.sv ====
`default_nettype none
module slcd_core #(
  parameter logic [15:0] OSC_DIV = slcd_pkg::OSC_DIV_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic chip_select_n,
  input wire logic serial_clk,
  input wire logic serial_data_in,
  input wire logic display_inhibit_n,
  input wire logic external_clock_pin,
  output logic drive_enable,
  output logic bias_half,
  output logic frame_inversion,
  output logic [1:0] power_mode,
  output logic [1:0] frame_rate,
  output logic ext_clock_sel,
  output logic [1:0] blink_mode,
  output logic [5:0] ram_addr,
  output logic frame_pulse,
  output logic [5:0] scan_addr,
  output logic [3:0] scan_data,
  output logic link_ready,
  output logic rx_overflow
);
  // Whole block state
  typedef struct packed {
    logic sclk_q;                       // Serial clock last sample
    logic ext_q;                        // External clock last sample
    logic [7:0] shift;                  // Incoming bits, MSB first
    logic [3:0] bits;                   // Bits taken in this unit
    logic next_data;                    // Never set; data mode is held in link
    slcd_pkg::slcd_link_t link;         // Framing state
    logic panel_on;                     // Command-driven panel state
    logic off_pending;                  // Off waiting for frame end
    slcd_pkg::slcd_bias_t bias;
    slcd_pkg::slcd_rate_t rate;
    slcd_pkg::slcd_wave_t wave;
    slcd_pkg::slcd_power_t power;
    logic addr_msb;                     // Stored address bit 5
    slcd_pkg::slcd_clksrc_t clk_src;
    logic [1:0] blink;
    logic [5:0] addr;                   // Display RAM write counter
    logic [15:0] osc_cnt;               // Internal tick divider
    logic [9:0] frame_cnt;              // Ticks into this frame
    logic [5:0] scan_addr;              // Refresh read pointer
    logic frame_pulse;                  // One cycle per frame end
    logic overflow;                     // Sticky receive loss
  } slcd_core_state_t;

  slcd_core_state_t s_r, s_nxt;

  // Receive-to-decoder queue signals
  logic push_valid;
  logic [8:0] push_data;
  logic fifo_in_ready;
  logic pop_valid;
  logic pop_ready;
  logic [8:0] pop_data;
  // Display RAM port
  logic ram_we;
  logic [5:0] ram_port_addr;
  logic [3:0] ram_rdata;
  // Decode helpers
  logic sclk_rise, sclk_fall;
  logic ext_rise;
  logic osc_wrap;
  logic tick;
  logic frame_end;
  logic scan_take;
  logic [9:0] frame_div;
  logic [7:0] cmd;
  logic is_data;
  logic [5:0] load_addr;

  // Queue between the serial front end and the decoder
  slcd_fifo #(
    .WIDTH(slcd_pkg::ENTRY_W),
    .DEPTH(slcd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_data)
  );

  // Display memory, shared by writes and refresh reads
  slcd_ram #(
    .WIDTH(slcd_pkg::NIB_W),
    .DEPTH(slcd_pkg::RAM_DEPTH),
    .AW(slcd_pkg::ADDR_W)
  ) u_ram (
    .clk(clk),
    .we(ram_we),
    .addr(ram_port_addr),
    .wdata(pop_data[3:0]),
    .rdata(ram_rdata)
  );

  // Edge detection on sampled pins
  assign sclk_rise = serial_clk & ~s_r.sclk_q;
  assign sclk_fall = ~serial_clk & s_r.sclk_q;
  assign ext_rise = external_clock_pin & ~s_r.ext_q;
  assign osc_wrap = (s_r.osc_cnt == OSC_DIV - slcd_pkg::OSC_STEP);

  // Logic clock tick from the selected source
  assign tick = (s_r.clk_src == slcd_pkg::CLK_EXTERNAL) ? ext_rise
                                                         : osc_wrap;

  // Ticks per frame for the chosen rate
  always_comb begin
    unique case (s_r.rate)
      slcd_pkg::RATE_80: frame_div = slcd_pkg::DIV_80;
      slcd_pkg::RATE_71: frame_div = slcd_pkg::DIV_71;
      slcd_pkg::RATE_64: frame_div = slcd_pkg::DIV_64;
      slcd_pkg::RATE_53: frame_div = slcd_pkg::DIV_53;
    endcase
  end

  assign frame_end = tick &
                     (s_r.frame_cnt == frame_div - slcd_pkg::FRAME_STEP);

  // Refresh owns the RAM port on its tick; the queue absorbs the stall
  assign scan_take = tick & s_r.panel_on;
  assign pop_ready = ~scan_take;
  assign cmd = pop_data[7:0];
  assign is_data = pop_data[8];
  assign ram_we = pop_valid & pop_ready & is_data;
  assign ram_port_addr = scan_take ? s_r.scan_addr : s_r.addr;

  // Address from the command's low bits and the stored MSB
  assign load_addr = {s_r.addr_msb,
                      cmd[slcd_pkg::ADDR_LO_HI:0]};

  // Next-state logic for link, decoder and frame timing
  always_comb begin
    s_nxt = s_r;
    push_valid = 1'b0;
    push_data = '0;
    s_nxt.sclk_q = serial_clk;
    s_nxt.ext_q = external_clock_pin;
    s_nxt.frame_pulse = frame_end;

    // Serial front end
    if (chip_select_n) begin
      // Idle link drops any partial unit
      s_nxt.bits = '0;
      s_nxt.link = slcd_pkg::LINK_IDLE;
      s_nxt.next_data = 1'b0;
    end else begin
      unique case (s_r.link)
        slcd_pkg::LINK_IDLE: begin
          // First byte of a frame is always a command
          s_nxt.link = slcd_pkg::LINK_CMD;
          s_nxt.bits = '0;
        end
        slcd_pkg::LINK_CMD, slcd_pkg::LINK_DATA: begin
          if (sclk_rise && s_r.bits != slcd_pkg::BITS_BYTE) begin
            // Shift in MSB first on the rising edge
            s_nxt.shift = {s_r.shift[6:0], serial_data_in};
            s_nxt.bits = s_r.bits + slcd_pkg::BITS_STEP;
          end
          if (sclk_fall) begin
            if (s_r.link == slcd_pkg::LINK_DATA &&
                (s_r.bits == slcd_pkg::BITS_NIB ||
                 s_r.bits == slcd_pkg::BITS_BYTE)) begin
              // Each completed nibble is one RAM entry
              push_valid = 1'b1;
              push_data = {1'b1, 4'h0, s_r.shift[3:0]};
              if (s_r.bits == slcd_pkg::BITS_BYTE) begin
                s_nxt.bits = '0;
              end
            end else if (s_r.link == slcd_pkg::LINK_CMD &&
                         s_r.bits == slcd_pkg::BITS_BYTE) begin
              // Whole command taken at the eighth falling edge
              push_valid = 1'b1;
              push_data = {1'b0, s_r.shift};
              s_nxt.bits = '0;
              if (!s_r.shift[slcd_pkg::CD_BIT]) begin
                // Stays in data until chip select rises
                s_nxt.link = slcd_pkg::LINK_DATA;
              end
            end
          end
        end
        default: begin
          s_nxt.link = slcd_pkg::LINK_IDLE;
        end
      endcase
    end
    // A full queue loses the unit; the host must pace itself
    if (push_valid && !fifo_in_ready) begin
      s_nxt.overflow = 1'b1;
    end

    // Internal oscillator divider runs continuously
    s_nxt.osc_cnt = osc_wrap ? '0 : s_r.osc_cnt + slcd_pkg::OSC_STEP;

    // Frame counter on the logic clock
    if (tick) begin
      s_nxt.frame_cnt = frame_end ? '0
                                  : s_r.frame_cnt + slcd_pkg::FRAME_STEP;
    end

    // Refresh pointer walks the whole RAM while the panel runs
    if (scan_take) begin
      s_nxt.scan_addr = (s_r.scan_addr == slcd_pkg::ADDR_LAST) ?
                        slcd_pkg::ADDR_FIRST :
                        s_r.scan_addr + slcd_pkg::ADDR_STEP;
    end

    // Deferred switch-off lands on the frame boundary
    if (frame_end && s_r.off_pending) begin
      s_nxt.panel_on = 1'b0;
      s_nxt.off_pending = 1'b0;
    end

    // Decoder
    if (pop_valid && pop_ready) begin
      if (is_data) begin
        // Advance after each nibble, wrapping after the last entry
        s_nxt.addr = (s_r.addr == slcd_pkg::ADDR_LAST) ?
                     slcd_pkg::ADDR_FIRST :
                     s_r.addr + slcd_pkg::ADDR_STEP;
      end else if (cmd[slcd_pkg::GRP_HI:slcd_pkg::GRP_LO] ==
                   slcd_pkg::GRP_MODE) begin
        // Only bits 3 and 2 are looked at
        if (cmd[slcd_pkg::PANEL_BIT]) begin
          s_nxt.panel_on = 1'b1;
          s_nxt.off_pending = 1'b0;
        end else if (s_r.panel_on) begin
          s_nxt.off_pending = 1'b1;
        end
        s_nxt.bias = slcd_pkg::slcd_bias_t'(cmd[slcd_pkg::BIAS_BIT]);
      end else if (cmd[slcd_pkg::GRP_HI:slcd_pkg::GRP_LO] ==
                   slcd_pkg::GRP_ADDR) begin
        // Out-of-range loads fall back to the first entry
        s_nxt.addr = (load_addr > slcd_pkg::ADDR_LAST) ?
                     slcd_pkg::ADDR_FIRST : load_addr;
      end else if (cmd[slcd_pkg::GRP_HI:slcd_pkg::GRP_LO] ==
                   slcd_pkg::GRP_DCTL) begin
        s_nxt.rate = slcd_pkg::slcd_rate_t'(
                     cmd[slcd_pkg::RATE_HI:slcd_pkg::RATE_LO]);
        s_nxt.wave = slcd_pkg::slcd_wave_t'(cmd[slcd_pkg::WAVE_BIT]);
        s_nxt.power = slcd_pkg::slcd_power_t'(cmd[1:0]);
      end else if (cmd[slcd_pkg::GRP_HI:slcd_pkg::OP_LO] ==
                   slcd_pkg::OP_CHIP) begin
        if (cmd[slcd_pkg::SRST_BIT]) begin
          // Config back to reset values, clock select from bit 0; RAM contents are kept
          s_nxt.panel_on = 1'b0;
          s_nxt.off_pending = 1'b0;
          s_nxt.bias = slcd_pkg::BIAS_THIRD;
          s_nxt.rate = slcd_pkg::RATE_80;
          s_nxt.wave = slcd_pkg::WAVE_LINE;
          s_nxt.power = slcd_pkg::PWR_NORMAL;
          s_nxt.blink = slcd_pkg::BLINK_RST;
          s_nxt.addr_msb = 1'b0;
          s_nxt.addr = slcd_pkg::ADDR_FIRST;
        end else begin
          // MSB is only stored; counter untouched
          s_nxt.addr_msb = cmd[slcd_pkg::MSB_BIT];
        end
        s_nxt.clk_src = slcd_pkg::slcd_clksrc_t'(
                        cmd[slcd_pkg::CLKSEL_BIT]);
      end else if (cmd[slcd_pkg::GRP_HI:slcd_pkg::OP_LO] ==
                   slcd_pkg::OP_BLINK) begin
        // Bit 2 is don't-care
        s_nxt.blink = cmd[1:0];
      end
      // Anything else, including all-pixel control, changes nothing
    end
  end

  // Single state register
  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '{sclk_q: 1'b0,
               ext_q: 1'b0,
               shift: '0,
               bits: '0,
               next_data: 1'b0,
               link: slcd_pkg::LINK_IDLE,
               panel_on: 1'b0,
               off_pending: 1'b0,
               bias: slcd_pkg::BIAS_THIRD,
               rate: slcd_pkg::RATE_80,
               wave: slcd_pkg::WAVE_LINE,
               power: slcd_pkg::PWR_NORMAL,
               addr_msb: 1'b0,
               clk_src: slcd_pkg::CLK_INTERNAL,
               blink: slcd_pkg::BLINK_RST,
               addr: slcd_pkg::ADDR_FIRST,
               osc_cnt: '0,
               frame_cnt: '0,
               scan_addr: slcd_pkg::ADDR_FIRST,
               frame_pulse: 1'b0,
               overflow: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Pin inhibit acts at once, outside the frame timing
  assign drive_enable = s_r.panel_on & display_inhibit_n;
  assign bias_half = (s_r.bias == slcd_pkg::BIAS_HALF);
  assign frame_inversion = (s_r.wave == slcd_pkg::WAVE_FRAME);
  assign power_mode = s_r.power;
  assign frame_rate = s_r.rate;
  assign ext_clock_sel = (s_r.clk_src == slcd_pkg::CLK_EXTERNAL);
  assign blink_mode = s_r.blink;
  assign ram_addr = s_r.addr;
  assign frame_pulse = s_r.frame_pulse;
  assign scan_addr = s_r.scan_addr;
  assign scan_data = ram_rdata;
  assign link_ready = fifo_in_ready;
  assign rx_overflow = s_r.overflow;
endmodule : slcd_core
`default_nettype wire

// ==== slcd_checker.sv ====
`default_nettype none
module slcd_checker #(
  parameter logic [15:0] OSC_DIV = 16'h0040
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic chip_select_n,
  input wire logic display_inhibit_n,
  input wire logic drive_enable,
  input wire logic bias_half,
  input wire logic frame_inversion,
  input wire logic [1:0] power_mode,
  input wire logic [1:0] frame_rate,
  input wire logic ext_clock_sel,
  input wire logic [1:0] blink_mode,
  input wire logic [5:0] ram_addr,
  input wire logic frame_pulse
);
  // Cycles since the last frame pulse
  logic [16:0] gap_r;
  // Last frame ran lit, with one rate and one source
  logic clean_r;
  // Frame length expected on the internal oscillator
  logic [16:0] exp_gap;

  // Ticks per frame times oscillator divider
  always_comb begin
    case (frame_rate)
      2'h0: exp_gap = 17'(512 * OSC_DIV);
      2'h1: exp_gap = 17'(576 * OSC_DIV);
      2'h2: exp_gap = 17'(648 * OSC_DIV);
      default: exp_gap = 17'(768 * OSC_DIV);
    endcase
  end

  // Frames cut short by a change are not judged
  always_ff @(posedge clk) begin
    if (reset) begin
      gap_r <= 17'h00001;
      clean_r <= 1'b0;
    end else begin
      gap_r <= frame_pulse ? 17'h00001 : gap_r + 17'h00001;
      if ($changed(frame_rate) || $changed(ext_clock_sel) || !drive_enable)
        clean_r <= 1'b0;
      else if (frame_pulse)
        clean_r <= 1'b1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_inhibit_blank: assert property (!display_inhibit_n |-> !drive_enable)
    else $error("drive enabled while inhibited");
  a_inhibit_release: assert property (chip_select_n && drive_enable ##1
    !display_inhibit_n ##1 display_inhibit_n && chip_select_n
    |-> drive_enable || frame_pulse)
    else $error("drive not back after inhibit");
  a_off_framed: assert property ($fell(drive_enable) && display_inhibit_n
    && $past(display_inhibit_n) |-> frame_pulse
    || (ram_addr == 6'h00 && power_mode == 2'h2 && !bias_half))
    else $error("panel off outside frame boundary");
  a_addr_range: assert property (ram_addr <= 6'h22)
    else $error("address counter out of range");
  a_frame_len: assert property (frame_pulse && clean_r && !ext_clock_sel
    |-> gap_r == exp_gap)
    else $error("frame length wrong");
  a_reset_vals: assert property ($past(reset) |-> !drive_enable && !bias_half
    && !frame_inversion && power_mode == 2'h2 && frame_rate == 2'h0
    && !ext_clock_sel && blink_mode == 2'h0 && ram_addr == 6'h00)
    else $error("wrong value after reset");
  a_idle_stable: assert property (chip_select_n [*8] ##1 chip_select_n [*8]
    |=> $stable(bias_half) && $stable(frame_rate) && $stable(power_mode)
    && $stable(blink_mode) && $stable(ram_addr) && $stable(ext_clock_sel)
    && $stable(frame_inversion))
    else $error("state changed while deselected");
  a_pulse_single: assert property (frame_pulse |=> !frame_pulse [*8])
    else $error("frame pulses too close");

  // Main scenarios
  c_panel_on: cover property ($rose(drive_enable));
  c_ext_frame: cover property (frame_pulse && ext_clock_sel);
  c_wrap: cover property ($past(ram_addr) == 6'h22 && ram_addr == 6'h00);
endmodule // slcd_checker

bind slcd_core slcd_checker #(.OSC_DIV(OSC_DIV)) u_chk (.clk(clk),
  .reset(reset), .chip_select_n(chip_select_n),
  .display_inhibit_n(display_inhibit_n), .drive_enable(drive_enable),
  .bias_half(bias_half), .frame_inversion(frame_inversion),
  .power_mode(power_mode), .frame_rate(frame_rate),
  .ext_clock_sel(ext_clock_sel), .blink_mode(blink_mode),
  .ram_addr(ram_addr), .frame_pulse(frame_pulse));
`default_nettype wire

// ==== slcd_host.sv ====
`default_nettype none
module slcd_host (
  input wire logic clk,
  output var logic chip_select_n,
  output var logic serial_clk,
  output var logic serial_data_in
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle link: deselected, clock parked low
  initial begin
    chip_select_n = 1'b1;
    serial_clk = 1'b0;
    serial_data_in = 1'b1;
  end

  // Open a frame; link needs a cycle to leave idle
  task sel;
    @(posedge clk);
    #1 chip_select_n = 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // Shift n bits, clock high two cycles, low three
  task put(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      @(posedge clk);
      #1 serial_data_in = b[i];
      repeat (2) @(posedge clk);
      #1 serial_clk = 1'b1;
      repeat (2) @(posedge clk);
      #1 serial_clk = 1'b0;
    end
  endtask

  // Close the frame; data line no longer holds its last bit
  task desel;
    repeat (2) @(posedge clk);
    #1 chip_select_n = 1'b1;
    serial_data_in = ~serial_data_in;
    repeat (2) @(posedge clk);
  endtask
endmodule // slcd_host
`default_nettype wire

// ==== slcd_core_test.sv ====
`default_nettype none
module slcd_core_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk;
  logic reset;
  logic display_inhibit_n;
  logic external_clock_pin;
  wire chip_select_n, serial_clk, serial_data_in;
  wire drive_enable, bias_half, frame_inversion, ext_clock_sel, frame_pulse;
  wire link_ready, rx_overflow;
  wire [1:0] power_mode, frame_rate, blink_mode;
  wire [5:0] ram_addr, scan_addr;
  wire [3:0] scan_data;
  // Packed view of all configuration outputs
  wire [15:0] cfg = {drive_enable, bias_half, frame_inversion, power_mode,
    frame_rate, ext_clock_sel, blink_mode, ram_addr};
  logic [15:0] e; // Expected configuration
  int error_cnt;
  int checked;
  int divs[4] = '{512, 576, 648, 768};

  // Small divider keeps frames short
  slcd_core #(.OSC_DIV(16'h0004)) u_dut (.clk(clk), .reset(reset),
    .chip_select_n(chip_select_n), .serial_clk(serial_clk),
    .serial_data_in(serial_data_in), .display_inhibit_n(display_inhibit_n),
    .external_clock_pin(external_clock_pin), .drive_enable(drive_enable),
    .bias_half(bias_half), .frame_inversion(frame_inversion),
    .power_mode(power_mode), .frame_rate(frame_rate),
    .ext_clock_sel(ext_clock_sel), .blink_mode(blink_mode),
    .ram_addr(ram_addr), .frame_pulse(frame_pulse), .scan_addr(scan_addr),
    .scan_data(scan_data), .link_ready(link_ready),
    .rx_overflow(rx_overflow));
  slcd_host u_host (.clk(clk), .chip_select_n(chip_select_n),
    .serial_clk(serial_clk), .serial_data_in(serial_data_in));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // External logic clock, one rising edge every four cycles
  initial begin
    external_clock_pin = 1'b0;
    forever begin
      repeat (2) @(posedge clk);
      #1 external_clock_pin = ~external_clock_pin;
    end
  end

  task finish_test;
    if (error_cnt == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Room for queue, pop and scan stalls
  task settle;
    repeat (12) @(posedge clk);
    #1 chk(cfg, e);
  endtask

  // Cycles up to the next frame pulse, bounded
  task wait_pulse(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (frame_pulse !== 1'b1 && n < 8000);
    if (n >= 8000) begin
      error_cnt++;
      $display("MISMATCH %0t: no frame pulse", $time);
      finish_test();
    end
  endtask

  // Every rate, waveform, power and blink code, one frame
  task t_config;
    logic [1:0] c;
    u_host.sel();
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      u_host.put({3'b101, c, c[0], c}, 8);
      e = {2'b00, c[0], c, c, 9'h000};
      settle;
    end
    u_host.put(8'hDF, 8);
    e[15:14] = 2'b11;
    settle;
    for (int m = 0; m < 4; m++) begin
      c = m[1:0];
      u_host.put({6'b111101, c}, 8);
      e[7:6] = c;
      settle;
    end
    u_host.put(8'hF8, 8);
    settle;
    u_host.desel();
  endtask

  // Pin blanks and restores at once
  task t_inhibit;
    @(posedge clk);
    #1 display_inhibit_n = 1'b0;
    #1 chk({15'h0000, drive_enable}, 16'h0000);
    @(posedge clk);
    #1 display_inhibit_n = 1'b1;
    #1 chk({15'h0000, drive_enable}, 16'h0001);
  endtask

  // Address load, wrap, data mode and persistence
  task t_addr;
    u_host.sel();
    u_host.put(8'hEC, 8);
    settle;
    u_host.put(8'h01, 8);
    e[5:0] = 6'h21;
    settle;
    u_host.put(8'h12, 8);
    e[5:0] = 6'h00;
    settle;
    u_host.put(8'hFF, 8);
    e[5:0] = 6'h02;
    settle;
    u_host.desel();
    u_host.sel();
    u_host.put(8'h70, 8);
    e[7:6] = 2'b00;
    settle;
    u_host.put(8'h5A, 8);
    e[5:0] = 6'h04;
    settle;
    u_host.desel();
    u_host.sel();
    u_host.put(8'hE8, 8);
    settle;
    u_host.put(8'h82, 8);
    e[5:0] = 6'h02;
    settle;
    u_host.put(8'hEC, 8);
    u_host.put(8'h82, 8);
    e[5:0] = 6'h22;
    settle;
    u_host.put(8'h83, 8);
    e[5:0] = 6'h00;
    settle;
    u_host.desel();
  endtask

  // Truncated panel-off command is dropped
  task t_partial;
    u_host.sel();
    u_host.put(8'hC0, 5);
    u_host.desel();
    settle;
  endtask

  // Panel off lands with the frame pulse; starts after a pulse so the
  // last lit frame is whole and can be timed
  task t_off;
    int n;
    logic seen;
    seen = 1'b0;
    wait_pulse(n);
    u_host.sel();
    u_host.put(8'hC4, 8);
    for (int i = 0; i < 8000 && drive_enable !== 1'b0; i++) begin
      @(posedge clk);
      #1 seen = frame_pulse;
    end
    chk({15'h0000, seen}, 16'h0001);
    chk({15'h0000, drive_enable}, 16'h0000);
    if (drive_enable !== 1'b0) finish_test();
    u_host.desel();
    e[15] = 1'b0;
    settle;
  endtask

  // Software reset drops MSB, counter and panel; bit0 still sets clock select
  task t_srst;
    u_host.sel();
    u_host.put(8'hC8, 8);
    e[15:14] = 2'b10;
    settle;
    u_host.put(8'h81, 8);
    e[5:0] = 6'h21;
    settle;
    u_host.put(8'hEF, 8);
    e = 16'h1100;
    settle;
    u_host.put(8'h82, 8);
    e[5:0] = 6'h02;
    settle;
    u_host.put(8'hC8, 8);
    e[15] = 1'b1;
    settle;
    u_host.desel();
  endtask

  // Refresh reads back the nibble stored at 02h
  task t_scan;
    int i;
    i = 0;
    while (scan_addr === 6'h03 && i < 9) begin
      @(posedge clk);
      #1 i++;
    end
    while (scan_addr !== 6'h03 && i < 300) begin
      @(posedge clk);
      #1 i++;
    end
    chk(16'(i >= 300), 16'h0000);
    if (i >= 300) finish_test();
    chk({12'h000, scan_data}, 16'h0005);
  endtask

  // Frame length on the external clock for each rate
  task t_ext;
    int n;
    logic [1:0] c;
    for (int r = 0; r < 4; r++) begin
      c = r[1:0];
      u_host.sel();
      u_host.put({3'b101, c, 3'b010}, 8);
      e[10:9] = c;
      settle;
      u_host.desel();
      wait_pulse(n);
      wait_pulse(n);
      chk(16'(n), 16'(divs[r] * 4));
    end
    chk({14'h0000, link_ready, rx_overflow}, 16'h0002);
  endtask

  initial begin
    error_cnt = 0;
    checked = 0;
    reset = 1'b1;
    display_inhibit_n = 1'b1;
    e = 16'h1000;
    repeat (2) @(posedge clk);
    #1 reset = 1'b0;
    @(posedge clk);
    #1 chk(cfg, e);
    t_config();
    t_inhibit();
    t_addr();
    t_partial();
    t_off();
    t_srst();
    t_scan();
    t_ext();
    finish_test();
  end
endmodule // slcd_core_test
`default_nettype wire
